// [verilog/sag_cmd.sv]
// Command decoder for analogue setup, amplifier gain, ramping, flash unlock and watchdog clear.
`default_nettype none
`include "sagr_params.svh"
module sag_cmd
	import sagr_pkg::*;
#(
	// Settle times of the device and analogue power transitions.
	parameter logic [15:0] PWR_SETTLE = `SAG_PWR_SETTLE,
	parameter logic [15:0] ANA_SETTLE = `SAG_ANA_SETTLE
)
(
	// Clock, reset and enable.
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Command bytes from the serial or I2C front end.
	input  wire logic        byte_valid,
	input  wire logic        byte_first,
	input  wire logic        byte_from_i2c,
	input  wire logic [7:0]  byte_data,
	input  wire logic        cmd_abort,
	// Configuration and playback status.
	input  wire sag_path_e   out_path,
	input  wire sag_fam_e    rate_family,
	input  wire logic        playing,
	input  wire logic [7:0]  stored_prot_code,
	input  wire logic [6:0]  level_target,
	// Power and analogue status.
	output sag_pwr_e         power_state,
	output sag_analog_s      analog_setup,
	output logic             amp_on,
	output logic             click_sup_active,
	output logic             analog_busy,
	// Amplifier gain.
	output logic      [3:0]  amp_gain_code,
	output logic signed [7:0] amp_gain_db,
	output logic             amp_mute,
	output logic             amp_gain_bad,
	// Ramp.
	output logic             ramp_enable,
	output logic      [2:0]  ramp_step_sel,
	output logic      [7:0]  ramp_step_size,
	output logic      [6:0]  ramp_level,
	output logic             ramp_busy,
	// Flash passthrough and watchdog.
	output logic             flash_passthrough,
	output logic             watchdog_clear
);

	// Gain code to dB, mute and prohibited codes read as zero.
	function automatic logic signed [7:0] gain_db(input logic [3:0] code);
		case (code)
			4'hf: gain_db = 8'sd12;
			4'he: gain_db = 8'sd10;
			4'hd: gain_db = 8'sd8;
			4'hc: gain_db = 8'sd6;
			4'hb: gain_db = 8'sd4;
			4'ha: gain_db = 8'sd2;
			4'h9: gain_db = 8'sd0;
			4'h8: gain_db = -8'sd4;
			4'h7: gain_db = -8'sd8;
			4'h6: gain_db = -8'sd12;
			4'h5: gain_db = -8'sd18;
			4'h4: gain_db = -8'sd26;
			4'h3: gain_db = -8'sd34;
			default: gain_db = 8'sd0;
		endcase
	endfunction : gain_db

	// Analogue output powered for a given path and enable pair.
	function automatic logic path_on(input sag_path_e path, input sag_analog_s a);
		case (path)
			// [R1] speaker enable decode
			SAG_PATH_SPK:  path_on = !a.amp_enable_high && a.amp_enable_low;
			// [R2] positive pin decode
			SAG_PATH_SPP:  path_on = a.amp_enable_high && !a.amp_enable_low;
			// [R3] line pin decode
			SAG_PATH_LINE_OUT_PIN: path_on = a.amp_enable_high && a.amp_enable_low;
			default:       path_on = 1'b0;
		endcase
	endfunction : path_on

	// Sampling-group period in clock cycles for each rate family.
	function automatic logic [15:0] group_cycles(input sag_fam_e fam);
		case (fam)
			SAG_FAM_107: group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_107_NS));
			SAG_FAM_64:  group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_64_NS));
			SAG_FAM_80:  group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_80_NS));
			SAG_FAM_110: group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_110_NS));
			SAG_FAM_120: group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_120_NS));
			default:     group_cycles = 16'(`SAG_NS2CYC(`SAG_TGRP_80_NS));
		endcase
	endfunction : group_cycles

	sag_state_s st;
	sag_state_s next_st;
	sag_byte_s  rx;

	// Incoming byte bundled for the decoder.
	assign rx = '{valid: byte_valid, first: byte_first, from_i2c: byte_from_i2c,
		data: byte_data};

	// Next-state logic: byte assembly, command decode and power sequencing.
	always_comb begin
		next_st          = st;
		// The watchdog clear is a single-cycle strobe.
		next_st.wd_clear = 1'b0;

		// Device power transitions run out their settle counts.
		case (st.pwr)
			SAG_PWR_RISE: begin
				if (st.pwr_cnt == 16'h0) begin
					next_st.pwr = SAG_PWR_STBY;
				end else begin
					next_st.pwr_cnt = st.pwr_cnt - 16'h1;
				end
			end
			SAG_PWR_FALL: begin
				if (st.pwr_cnt == 16'h0) begin
					next_st.pwr = SAG_PWR_DOWN;
				end else begin
					next_st.pwr_cnt = st.pwr_cnt - 16'h1;
				end
			end
			SAG_PWR_DOWN, SAG_PWR_STBY: begin
				// Stable states hold.
				next_st.pwr_cnt = st.pwr_cnt;
			end
			default: begin
				next_st.pwr = SAG_PWR_DOWN;
			end
		endcase

		// Analogue transition timer; click suppression spans it.
		if (st.ana_trans) begin
			if (st.ana_cnt == 16'h0) begin
				next_st.ana_trans = 1'b0;
			end else begin
				next_st.ana_cnt = st.ana_cnt - 16'h1;
			end
		end

		// [R20] partial command dropped
		if (cmd_abort) begin
			next_st.wait2 = 1'b0;
		end else if (rx.valid && st.wait2 && !rx.first) begin
			// Second byte completes a two-byte command.
			next_st.wait2 = 1'b0;
			case (st.op)
				// [R5] gain loaded anytime
				`SAG_OP_GAIN: begin
					if (st.pwr != SAG_PWR_DOWN) begin
						next_st.gain = rx.data[5:2];
					end
				end
				// [R9] ramp setup anytime
				`SAG_OP_RAMP: begin
					if (st.pwr != SAG_PWR_DOWN) begin
						next_st.ramp_en  = rx.data[0];
						next_st.step_sel = rx.data[3:1];
					end
				end
				`SAG_OP_FLASH: begin
					// [R13] I2C unlock ignored
					// [R14] code match unlock
					if (!st.op_i2c && st.pwr == SAG_PWR_STBY
							&& stored_prot_code != `SAG_LOCK_NEVER
							&& rx.data == stored_prot_code) begin
						next_st.flash_mode = 1'b1;
					end
				end
				default: begin
					// Analogue setup, the only other two-byte opcode kept here.
					// [R18] setup ignored when busy
					if (st.op[7:2] == `SAG_OP_ASETUP && st.pwr == SAG_PWR_STBY
							&& !playing && !st.ana_trans) begin
						next_st.ana = '{amp_class_sel: st.op[1], hpf: st.op[0],
							fade_out: rx.data[7], dac_gain: rx.data[6:5],
							ain_gain: rx.data[4:3], amp_enable_high: rx.data[2],
							amp_enable_low: rx.data[1], click_sup: rx.data[0]};
						next_st.ana_on = path_on(out_path, next_st.ana);
						// A change of output power starts a timed transition.
						if (next_st.ana_on != st.ana_on) begin
							next_st.ana_trans = 1'b1;
							next_st.ana_cnt   = ANA_SETTLE;
						end
					end
				end
			endcase
		end else if (rx.valid) begin
			// First byte of a new command; any half-taken one is discarded.
			next_st.wait2  = 1'b0;
			next_st.op     = rx.data;
			next_st.op_i2c = rx.from_i2c;
			if (rx.data == `SAG_OP_GAIN || rx.data == `SAG_OP_RAMP
					|| rx.data == `SAG_OP_FLASH || rx.data[7:2] == `SAG_OP_ASETUP) begin
				next_st.wait2 = 1'b1;
			end else if (rx.data[7:1] == `SAG_OP_PUP) begin
				// Power-up is the only command taken while powered down.
				if (st.pwr == SAG_PWR_DOWN) begin
					next_st.pwr     = SAG_PWR_RISE;
					next_st.pwr_cnt = PWR_SETTLE;
				end
			end else if (rx.data[7:1] == `SAG_OP_POWER_DOWN_CMD) begin
				if (st.pwr == SAG_PWR_STBY && !playing) begin
					next_st.pwr     = SAG_PWR_FALL;
					next_st.pwr_cnt = PWR_SETTLE;
					// [R19] setup fields reinitialised
					next_st.ana       = '0;
					next_st.ana_on    = 1'b0;
					next_st.ana_trans = 1'b0;
					next_st.ana_cnt   = '0;
					// [R7] gain restored on power-down
					next_st.gain      = `SAG_GAIN_INIT;
					next_st.ramp_en   = 1'b0;
					next_st.step_sel  = '0;
				end
			end else if (rx.data == `SAG_OP_WDCLR) begin
				// [R17] watchdog clear anytime
				next_st.wd_clear = st.pwr != SAG_PWR_DOWN;
			end else begin
				// Playback halt and other commands leave the gain untouched.
				next_st.gain = st.gain;
			end
		end

		// [R15] flash mode sticky
		if (st.flash_mode) begin
			next_st.flash_mode = 1'b1;
		end
	end

	// State register; reset brings every setting to its initial value.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st <= '0;
			st.pwr <= SAG_PWR_DOWN;
			// [R6] gain initial code
			st.gain <= `SAG_GAIN_INIT;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Level ramp, paced by the sampling-group period of the rate family.
	sag_ramp u_ramp (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.ce        (ce),
		.enable    (st.ramp_en),
		.step_sel  (st.step_sel),
		.group_cyc (group_cycles(rate_family)),
		.target    (level_target),
		.level     (ramp_level),
		.busy      (ramp_busy),
		.step_size (ramp_step_size)
	);

	// Status outputs, taken from the state register; click suppression also decodes out_path.
	assign power_state       = st.pwr;
	assign analog_setup      = st.ana;
	assign amp_on            = st.ana_on;
	assign analog_busy       = st.ana_trans;
	// [R4] click suppression on lines
	assign click_sup_active  = st.ana_trans && st.ana.click_sup && out_path != SAG_PATH_SPK;
	assign amp_gain_code     = st.gain;
	// [R8] gain code mapping
	assign amp_gain_db       = gain_db(st.gain);
	assign amp_mute          = st.gain == `SAG_GAIN_MUTE;
	assign amp_gain_bad      = st.gain == `SAG_GAIN_BAD_LO || st.gain == `SAG_GAIN_BAD_HI;
	assign ramp_enable       = st.ramp_en;
	assign ramp_step_sel     = st.step_sel;
	assign flash_passthrough = st.flash_mode;
	assign watchdog_clear    = st.wd_clear;

endmodule : sag_cmd
`default_nettype wire

// [inc/sagr_params.svh]
// Constants for the speech amplifier, gain and ramp command decoder.
// Functional notes
// [R1] Speaker path: low enable only powers up.
// [R2] Line on positive pin: high enable only.
// [R3] Line on dedicated pin: both enables set.
// [R4] Line modes honour click-suppression bit on transitions.
// [R5] Gain command taken anytime, four-bit code.
// [R6] Gain code after reset is eight.
// [R7] Halt keeps gain; power-down restores it.
// [R8] Gain code maps to dB, mute, prohibited.
// [R9] Ramp command anytime; enable steps levels.
// [R10] Step size halves per selector increment.
// [R11] Transition time: difference times ceiling factor.
// [R12] Group period follows sample-rate family.
// [R13] Flash unlock ignored when sent over I2C.
// [R14] Unlock only on code match, never 0x69.
// [R15] Flash mode held until chip reset.
// [R16] Host sends unlock after power-up, serially.
// [R17] Watchdog clear taken anytime, zeroes counter.
// [R18] Analog setup ignored while busy or off.
// [R19] Analog setup fields reinitialised on power-down.
// [R20] Two-byte command acts only when complete.
`ifndef SAGR_PARAMS_SVH
`define SAGR_PARAMS_SVH

// Command opcodes, first byte.
`define SAG_OP_PUP        7'h00
`define SAG_OP_POWER_DOWN_CMD       7'h10
`define SAG_OP_ASETUP     6'h01
`define SAG_OP_GAIN       8'h08
`define SAG_OP_RAMP       8'h0c
`define SAG_OP_FLASH      8'h10
`define SAG_OP_WDCLR      8'h14
`define SAG_OP_HALT       4'h6

// Reset values and special codes.
`define SAG_GAIN_INIT     4'h8
`define SAG_LOCK_NEVER    8'h69
`define SAG_GAIN_MUTE     4'h0
`define SAG_GAIN_BAD_LO   4'h1
`define SAG_GAIN_BAD_HI   4'h2
`define SAG_GAIN_ZERO_DB  4'h9

// Clock rate and sampling-group periods in ns.
`define SAG_CLK_MHZ       40
`define SAG_TGRP_107_NS   23440
`define SAG_TGRP_64_NS    39060
`define SAG_TGRP_80_NS    31250
`define SAG_TGRP_110_NS   22680
`define SAG_TGRP_120_NS   20830
`define SAG_NS2CYC(t)     (((t) * `SAG_CLK_MHZ) / 1000)

// Ramp arithmetic: step scale and transition factor.
`define SAG_STEP_MAX      8'h80
`define SAG_RAMP_NUM      264
`define SAG_RAMP_DEN_LOG  8

// Default settle times in clock cycles.
`define SAG_PWR_SETTLE    16'h0100
`define SAG_ANA_SETTLE    16'h0400

`endif

// [inc/sagr_pkg.sv]
// Types shared by the command decoder and its ramp engine.
`default_nettype none
package sagr_pkg;

	// Device power state, Gray coded along power-up then power-down.
	typedef enum logic [1:0] {
		SAG_PWR_DOWN = 2'h0,
		SAG_PWR_RISE = 2'h1,
		SAG_PWR_STBY = 2'h3,
		SAG_PWR_FALL = 2'h2
	} sag_pwr_e;

	// Which analogue output the board uses.
	typedef enum logic [1:0] {
		SAG_PATH_SPK  = 2'h0,
		SAG_PATH_SPP  = 2'h1,
		SAG_PATH_LINE_OUT_PIN = 2'h2
	} sag_path_e;

	// Sampling-rate family.
	typedef enum logic [2:0] {
		SAG_FAM_107 = 3'h0,
		SAG_FAM_64  = 3'h1,
		SAG_FAM_80  = 3'h2,
		SAG_FAM_110 = 3'h3,
		SAG_FAM_120 = 3'h4
	} sag_fam_e;

	// One received command byte.
	typedef struct packed {
		logic       valid;
		logic       first;
		logic       from_i2c;
		logic [7:0] data;
	} sag_byte_s;

	// Analogue setup fields.
	typedef struct packed {
		logic       amp_class_sel;
		logic       hpf;
		logic       fade_out;
		logic [1:0] dac_gain;
		logic [1:0] ain_gain;
		logic       amp_enable_high;
		logic       amp_enable_low;
		logic       click_sup;
	} sag_analog_s;

	// Ramp engine state.
	typedef struct packed {
		logic [15:0] grp_cnt;
		logic [7:0]  tick_cnt;
		logic [6:0]  level;
	} sag_ramp_s;

	// Decoder state.
	typedef struct packed {
		sag_pwr_e    pwr;
		logic        wait2;
		logic [7:0]  op;
		logic        op_i2c;
		sag_analog_s ana;
		logic        ana_on;
		logic        ana_trans;
		logic [15:0] ana_cnt;
		logic [15:0] pwr_cnt;
		logic [3:0]  gain;
		logic        ramp_en;
		logic [2:0]  step_sel;
		logic        flash_mode;
		logic        wd_clear;
	} sag_state_s;

endpackage : sagr_pkg
`default_nettype wire

// [verilog/sag_ramp.sv]
// Level ramp engine stepping one level toward a target every ticks_per_level sampling groups.
`default_nettype none
`include "sagr_params.svh"
module sag_ramp
	import sagr_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// Ramp setup.
	input  wire logic        enable,
	input  wire logic [2:0]  step_sel,
	input  wire logic [15:0] group_cyc,
	input  wire logic [6:0]  target,
	// Ramp output.
	output logic      [6:0]  level,
	output logic             busy,
	output logic      [7:0]  step_size
);

	// Group periods per level unit, the ceiling of 264 * 2^sel / 256.
	function automatic logic [7:0] ticks_per_level(input logic [2:0] sel);
		logic [15:0] num;
		num = 16'(`SAG_RAMP_NUM) << sel;
		ticks_per_level = 8'((num + 16'((1 << `SAG_RAMP_DEN_LOG) - 1)) >> `SAG_RAMP_DEN_LOG);
	endfunction : ticks_per_level

	sag_ramp_s st;
	sag_ramp_s next_st;

	// Step size is half as large for each selector increment.
	always_comb begin
		// [R10] step size scale
		step_size = `SAG_STEP_MAX >> step_sel;
	end

	// Next-state logic: count group periods, then move one level unit.
	always_comb begin
		next_st = st;
		if (!enable) begin
			// Without ramping the level jumps straight to the target.
			next_st.level    = target;
			next_st.grp_cnt  = '0;
			next_st.tick_cnt = '0;
		end else if (st.level != target) begin
			// [R12] group period count
			if (st.grp_cnt + 16'h1 >= group_cyc) begin
				next_st.grp_cnt = '0;
				// [R11] ceiling factor pacing
				if (st.tick_cnt + 8'h1 >= ticks_per_level(step_sel)) begin
					next_st.tick_cnt = '0;
					// [R9] stepwise move
					if (st.level < target) begin
						next_st.level = st.level + 7'h1;
					end else begin
						next_st.level = st.level - 7'h1;
					end
				end else begin
					next_st.tick_cnt = st.tick_cnt + 8'h1;
				end
			end else begin
				next_st.grp_cnt = st.grp_cnt + 16'h1;
			end
		end else begin
			// At target the counters rest so the next move starts clean.
			next_st.grp_cnt  = '0;
			next_st.tick_cnt = '0;
		end
	end

	// State register; the clock enable freezes everything.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign level = st.level;
	assign busy  = enable && (st.level != target);

endmodule : sag_ramp
`default_nettype wire

// [testbench/sagr_checker.sv]
// Assertion checker for the command decoder ports.
`default_nettype none
module sagr_checker
	import sagr_pkg::*;
(
	// Clock, reset and command bytes.
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic        byte_valid,
	input wire logic        byte_first,
	input wire logic        byte_from_i2c,
	input wire logic [7:0]  byte_data,
	input wire logic        cmd_abort,
	// Status and settings.
	input wire logic        playing,
	input wire logic [7:0]  stored_prot_code,
	input wire sag_pwr_e    power_state,
	input wire sag_analog_s analog_setup,
	input wire logic        analog_busy,
	input wire logic [3:0]  amp_gain_code,
	input wire logic        amp_mute,
	input wire logic        amp_gain_bad,
	input wire logic        ramp_enable,
	input wire logic [2:0]  ramp_step_sel,
	input wire logic [7:0]  ramp_step_size,
	input wire logic        flash_passthrough,
	input wire logic        watchdog_clear
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// A byte taken while in standby; gain and clear act in every power state except power-down.
	wire logic       take = ce && byte_valid && power_state == SAG_PWR_STBY;
	// Gain field of the second byte.
	wire logic [3:0] gain_in = byte_data[5:2];

	gain_reset_a: assert property (disable iff (1'b0) reset && ce |=>
		amp_gain_code == 4'h8) else $error("gain not eight after reset");
	gain_load_a: assert property (take && byte_first && byte_data == 8'h08
		##1 take && !byte_first && !cmd_abort |=> amp_gain_code == $past(gain_in))
		else $error("gain code not loaded");
	gain_map_a: assert property (amp_mute == (amp_gain_code == 4'h0) &&
		amp_gain_bad == (amp_gain_code inside {4'h1, 4'h2})) else $error("gain flags wrong");
	down_init_a: assert property (power_state == SAG_PWR_DOWN |-> amp_gain_code == 4'h8
		&& analog_setup == '0 && !ramp_enable) else $error("settings kept in power-down");
	step_size_a: assert property (ramp_step_size == (8'h80 >> ramp_step_sel))
		else $error("ramp step size wrong");
	wd_pulse_a: assert property (take && byte_first && byte_data == 8'h14 |=>
		watchdog_clear ##1 !watchdog_clear) else $error("watchdog clear pulse wrong");
	flash_entry_a: assert property ($rose(flash_passthrough) |->
		$past(byte_data) == $past(stored_prot_code) && $past(stored_prot_code) != 8'h69
		&& !$past(byte_from_i2c)) else $error("flash mode entered wrongly");
	flash_hold_a: assert property (flash_passthrough |=> flash_passthrough)
		else $error("flash mode left");
	setup_gate_a: assert property ($changed(analog_setup) |-> analog_setup == '0 ||
		($past(power_state) == SAG_PWR_STBY && !$past(playing) && !$past(analog_busy)))
		else $error("analogue setup changed while busy");
endmodule : sagr_checker
bind sag_cmd sagr_checker sagr_checker_i (.sys_clk(sys_clk), .reset(reset), .ce(ce),
	.byte_valid(byte_valid), .byte_first(byte_first), .byte_from_i2c(byte_from_i2c),
	.byte_data(byte_data), .cmd_abort(cmd_abort), .playing(playing),
	.stored_prot_code(stored_prot_code), .power_state(power_state),
	.analog_setup(analog_setup), .analog_busy(analog_busy), .amp_gain_code(amp_gain_code),
	.amp_mute(amp_mute), .amp_gain_bad(amp_gain_bad), .ramp_enable(ramp_enable),
	.ramp_step_sel(ramp_step_sel), .ramp_step_size(ramp_step_size),
	.flash_passthrough(flash_passthrough), .watchdog_clear(watchdog_clear));
`default_nettype wire

// [testbench/sagr_host.sv]
// Host model that hands command bytes to the decoder.
`default_nettype none
module sagr_host (
	// Clock.
	input  wire logic  sys_clk,
	// Command byte lines.
	output logic       byte_valid,
	output logic       byte_first,
	output logic       byte_from_i2c,
	output logic [7:0] byte_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines idle at time zero.
	initial begin
		byte_valid = 1'b0;
		byte_first = 1'b0;
		byte_from_i2c = 1'b0;
		byte_data = 8'h00;
	end

	// unlock sent serially
	// Presents one byte; it is taken at the next edge, so calls may run back to back.
	task automatic put(input logic first, input logic [7:0] data, input logic i2c);
		@(posedge sys_clk);
		#1;
		byte_valid = 1'b1;
		byte_first = first;
		byte_from_i2c = i2c;
		byte_data = data;
	endtask : put

	// Releases the lines; stale data is inverted so nothing reads it as fresh.
	task automatic done();
		@(posedge sys_clk);
		#1;
		byte_valid = 1'b0;
		byte_data = ~byte_data;
	endtask : done
endmodule : sagr_host
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the command decoder.
`default_nettype none
module testbench
	import sagr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] d; logic [3:0] c; logic signed [7:0] db; logic m; logic b;} sagr_g_s;
	typedef struct {sag_path_e p; logic [7:0] d; logic on; logic cs;} sagr_a_s;
	// Stimulus.
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        abort = 1'b0;
	logic        playing = 1'b0;
	logic [7:0]  prot = 8'h5a;
	logic [6:0]  target = 7'h00;
	sag_path_e   path = SAG_PATH_SPK;
	sag_fam_e    fam = SAG_FAM_107;
	wire logic   bv;
	wire logic   bf;
	wire logic   bi;
	wire logic [7:0] bd;
	// Observed outputs.
	sag_pwr_e    pwr;
	sag_analog_s ana;
	logic        amp_on, cs, busy, ren, rbusy, flash, wd, mute, bad;
	logic [3:0]  gain;
	logic signed [7:0] db;
	logic [2:0]  sel;
	logic [7:0]  step;
	logic [6:0]  lvl;
	int          err_count = 0;
	int          compares = 0;
	// Gain rows: second byte, code, dB, mute, prohibited.
	sagr_g_s gr[11] = '{'{8'h3c,4'hf,8'sd12,0,0}, '{8'h24,4'h9,8'sd0,0,0},
		'{8'h20,4'h8,-8'sd4,0,0}, '{8'h1c,4'h7,-8'sd8,0,0}, '{8'h18,4'h6,-8'sd12,0,0},
		'{8'h14,4'h5,-8'sd18,0,0}, '{8'h10,4'h4,-8'sd26,0,0}, '{8'h0c,4'h3,-8'sd34,0,0},
		'{8'h08,4'h2,8'sd0,0,1}, '{8'h04,4'h1,8'sd0,0,1}, '{8'h00,4'h0,8'sd0,1,0}};
	// Analogue rows: path, setup byte, power on, click suppression seen.
	sagr_a_s ar[5] = '{'{SAG_PATH_SPK,8'h03,1,0}, '{SAG_PATH_SPP,8'h05,1,1},
		'{SAG_PATH_LINE_OUT_PIN,8'h06,1,0}, '{SAG_PATH_LINE_OUT_PIN,8'h04,0,0}, '{SAG_PATH_SPP,8'h02,0,0}};

	sagr_host sagr_host_i (.sys_clk(sys_clk), .byte_valid(bv), .byte_first(bf),
		.byte_from_i2c(bi), .byte_data(bd));
	// Short settle times keep the run brief.
	sag_cmd #(.PWR_SETTLE(16'h0002), .ANA_SETTLE(16'h0002)) sag_cmd_i (.sys_clk(sys_clk),
		.reset(reset), .ce(ce), .byte_valid(bv), .byte_first(bf), .byte_from_i2c(bi),
		.byte_data(bd), .cmd_abort(abort), .out_path(path), .rate_family(fam),
		.playing(playing), .stored_prot_code(prot), .level_target(target),
		.power_state(pwr), .analog_setup(ana), .amp_on(amp_on), .click_sup_active(cs),
		.analog_busy(busy), .amp_gain_code(gain), .amp_gain_db(db), .amp_mute(mute),
		.amp_gain_bad(bad), .ramp_enable(ren), .ramp_step_sel(sel), .ramp_step_size(step),
		.ramp_level(lvl), .ramp_busy(rbusy), .flash_passthrough(flash), .watchdog_clear(wd));

	// Compares one value and counts it.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Sends a whole command; returns just after the edge that took its last byte.
	task automatic cmd(input logic [7:0] op, input logic two, input logic [7:0] arg,
			input logic i2c);
		sagr_host_i.put(1'b1, op, i2c);
		if (two) begin
			sagr_host_i.put(1'b0, arg, i2c);
		end
		sagr_host_i.done();
	endtask : cmd

	// Waits, bounded, until no power or analogue transition runs.
	task automatic settle();
		for (int i = 0; i < 40 && (pwr inside {SAG_PWR_RISE, SAG_PWR_FALL} || busy !== 1'b0);
				i++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask : settle

	// Free-running clock.
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Watchdog: the tests need well under half this span.
	initial begin
		#(25 * 20000);
		err_count++;
		give_verdict();
	end

	initial begin
		int g;
		repeat (5) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		check("gain", gain, 4'h8);
		check("ramp_en", ren, 1'b0);
		check("setup", ana, '0);
		cmd(8'h00, 1'b0, 8'h00, 1'b0);
		settle();
		check("power", pwr, SAG_PWR_STBY);
		$display("reset and power-up done");
		// Gain is taken even during playback.
		playing = 1'b1;
		foreach (gr[i]) begin
			cmd(8'h08, 1'b1, gr[i].d, 1'b0);
			check("gain", gain, gr[i].c);
			check("gain_db", db, gr[i].db);
			check("mute_bad", {mute, bad}, {gr[i].m, gr[i].b});
		end
		$display("gain table done");
		// A dropped or overtaken first byte changes nothing.
		sagr_host_i.put(1'b1, 8'h08, 1'b0);
		sagr_host_i.done();
		abort = 1'b1;
		@(posedge sys_clk);
		#1;
		abort = 1'b0;
		sagr_host_i.put(1'b0, 8'h3c, 1'b0);
		sagr_host_i.put(1'b1, 8'h08, 1'b0);
		cmd(8'h14, 1'b0, 8'h00, 1'b0);
		check("wd", wd, 1'b1);
		check("gain", gain, 4'h0);
		@(posedge sys_clk);
		#1;
		check("wd", wd, 1'b0);
		playing = 1'b0;
		$display("partial and clear done");
		for (int s = 7; s >= 0; s--) begin
			cmd(8'h0c, 1'b1, {4'h0, s[2:0], 1'b1}, 1'b0);
			check("ramp", {ren, sel}, {1'b1, s[2:0]});
			check("step", step, 8'h80 >> s);
		end
		// Selector 0: two group periods per level unit, both full since the counters rest at target.
		for (int k = 0; k < 2; k++) begin
			fam = k ? SAG_FAM_80 : SAG_FAM_107;
			g = k ? 1250 : 937;
			target = k ? 7'h00 : 7'h01;
			repeat (930) @(posedge sys_clk);
			#1;
			check("lvl_hold", lvl, {6'h0, k[0]});
			check("rbusy", rbusy, 1'b1);
			repeat (2 * g - 922) @(posedge sys_clk);
			#1;
			check("lvl_move", lvl, {6'h0, ~k[0]});
		end
		$display("ramp done");
		foreach (ar[i]) begin
			path = ar[i].p;
			cmd(8'h04, 1'b1, ar[i].d, 1'b0);
			check("setup", ana, {2'b00, ar[i].d});
			check("click", cs, ar[i].cs);
			settle();
			check("amp_on", amp_on, ar[i].on);
			cmd(8'h04, 1'b1, {7'h00, ar[i].d[0]}, 1'b0);
			settle();
			check("amp_off", amp_on, 1'b0);
		end
		playing = 1'b1;
		cmd(8'h04, 1'b1, 8'h02, 1'b0);
		check("setup", ana, 10'h000);
		playing = 1'b0;
		$display("analogue setup done");
		cmd(8'h08, 1'b1, 8'h3c, 1'b0);
		cmd(8'h61, 1'b0, 8'h00, 1'b0);
		check("gain", gain, 4'hf);
		cmd(8'h10, 1'b1, 8'h5a, 1'b1);
		check("flash", flash, 1'b0);
		cmd(8'h10, 1'b1, 8'h5b, 1'b0);
		check("flash", flash, 1'b0);
		prot = 8'h69;
		cmd(8'h10, 1'b1, 8'h69, 1'b0);
		check("flash", flash, 1'b0);
		prot = 8'h5a;
		cmd(8'h10, 1'b1, 8'h5a, 1'b0);
		check("flash", flash, 1'b1);
		cmd(8'h20, 1'b0, 8'h00, 1'b0);
		settle();
		check("pd", {pwr, gain, ana, ren}, {SAG_PWR_DOWN, 4'h8, 10'h000, 1'b0});
		check("flash", flash, 1'b1);
		reset = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		check("flash", flash, 1'b0);
		$display("halt, unlock and power-down done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
